// ===== hcsr_regs.sv
// hub configuration and status register bank with power-switch strap decode
// Functional notes
// - upper bits of both registers are read-only and read zero.
// - in eeprom mode the reserved bit 0 loads from eeprom data.
// - in smbus mode the host may overwrite the reserved bit.
// - interface reset returns target interface and registers to reset values.
// - interface reset set by writing one in smbus mode, cleared by hardware, zero ignored.
// - configuration-active flag set on entering eeprom or smbus mode.
// - upstream connection withheld while configuration-active reads one.
// - in eeprom mode the flag clears when leaving that mode.
// - flag clears on writing one; writing zero leaves it unchanged.
// - suspend strap low makes downstream power enables active low.
// - grouped-power strap low gives individual per-port power control.
// - full power management strap low enables full power management.
`default_nettype none
module hcsr_regs #(
  parameter int NUM_PORTS = 4
) (
  // clock, reset, enable
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  // mode entry/exit from the configuration engine (same clock)
  input  wire hcsr_pkg::hcsr_mode_e   config_mode,
  input  wire logic                   eeprom_load_valid,
  input  wire logic                   eeprom_reserved_config_bit_bit,
  // smbus target register access (same clock)
  input  wire hcsr_pkg::hcsr_req_s    host_req,
  output logic [7:0]                  host_rdata,
  output logic                        host_rvalid,
  // straps (asynchronous pins)
  input  wire logic                   high_speed_suspend_strap,
  input  wire logic                   grouped_power_strap,
  input  wire logic                   full_power_management_strap,
  // per-port power requests from hub logic
  input  wire logic [NUM_PORTS-1:0]   port_power_req,
  // outputs to the rest of the hub
  output logic                        reserved_bit,
  output logic                        upstream_connect_en,
  output logic                        target_if_reset,
  output logic [NUM_PORTS-1:0]        power_switch_en,
  output logic                        full_power_mgmt_en
);
  import hcsr_pkg::*;

  logic                  reserved_config_bit;
  logic                  configuration_in_progress;
  logic                  target_interface_reset;
  logic [HCSR_CNT_W-1:0] rst_cnt;
  logic                  rst_done;
  hcsr_mode_e            mode_q;
  logic                  enter_cfg;
  logic                  leave_eeprom;
  logic                  wr_reserved_config_bit;
  logic                  wr_stat;
  logic [2:0]            strap_sync;
  logic                  strap_seen;
  logic [1:0]            strap_age;
  hcsr_straps_s          straps;
  logic                  grouped_on;

  hcsr_sync #(.WIDTH(3)) u_strap_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in ({high_speed_suspend_strap, grouped_power_strap, full_power_management_strap}),
    .sync_out (strap_sync)
  );

  assign enter_cfg    = (config_mode != HCSR_MODE_PINS) && (mode_q == HCSR_MODE_PINS);
  assign leave_eeprom = (mode_q == HCSR_MODE_EEPROM) && (config_mode != HCSR_MODE_EEPROM);
  // only smbus writes reach the reserved bit; eeprom data arrive on their own port
  assign wr_reserved_config_bit      = host_req.wr && (config_mode == HCSR_MODE_SMBUS) &&
                        (host_req.addr == HCSR_OFS_RESERVED_CONFIG_BIT_CFG);
  assign wr_stat      = host_req.wr && (host_req.addr == HCSR_OFS_STATUS_CMD);
  assign rst_done     = target_interface_reset && (rst_cnt == HCSR_CNT_W'(HCSR_IF_RST_CYCLES - 1));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode_q <= HCSR_MODE_PINS;
    end else if (clk_en) begin
      mode_q <= config_mode;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rst_cnt <= '0;
    end else if (clk_en) begin
      if (!target_interface_reset || rst_done) begin
        rst_cnt <= '0;
      end else begin
        rst_cnt <= rst_cnt + HCSR_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      target_interface_reset <= 1'b0;
    end else if (clk_en) begin
      if (rst_done) begin
        target_interface_reset <= 1'b0;
      end else if (wr_stat && config_mode == HCSR_MODE_SMBUS && host_req.wdata[HCSR_BIT_IF_RST]) begin
        target_interface_reset <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reserved_config_bit <= HCSR_RESET_VAL[HCSR_BIT_RSVD0];
    end else if (clk_en) begin
      if (rst_done) begin
        reserved_config_bit <= HCSR_RESET_VAL[HCSR_BIT_RSVD0];
      end else if (config_mode == HCSR_MODE_EEPROM && eeprom_load_valid) begin
        reserved_config_bit <= eeprom_reserved_config_bit_bit;
      end else if (wr_reserved_config_bit) begin
        reserved_config_bit <= host_req.wdata[HCSR_BIT_RSVD0];
      end
    end
  end

  // hardware set wins over a host clear in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      configuration_in_progress <= HCSR_RESET_VAL[HCSR_BIT_CFG_ACT];
    end else if (clk_en) begin
      if (enter_cfg) begin
        configuration_in_progress <= 1'b1;
      end else if (leave_eeprom) begin
        configuration_in_progress <= 1'b0;
      end else if (wr_stat && host_req.wdata[HCSR_BIT_CFG_ACT]) begin
        configuration_in_progress <= 1'b0;
      end else if (rst_done) begin
        configuration_in_progress <= HCSR_RESET_VAL[HCSR_BIT_CFG_ACT];
      end
    end
  end

  // read port; upper bits zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      host_rdata  <= HCSR_ZERO_BYTE;
      host_rvalid <= 1'b0;
    end else if (clk_en) begin
      host_rvalid <= host_req.rd;
      host_rdata  <= HCSR_ZERO_BYTE;
      if (host_req.rd) begin
        if (host_req.addr == HCSR_OFS_RESERVED_CONFIG_BIT_CFG) begin
          host_rdata[HCSR_BIT_RSVD0] <= reserved_config_bit;
        end else if (host_req.addr == HCSR_OFS_STATUS_CMD) begin
          host_rdata[HCSR_BIT_IF_RST]  <= target_interface_reset;
          host_rdata[HCSR_BIT_CFG_ACT] <= configuration_in_progress;
        end
      end
    end
  end

  // the synchroniser shows its reset zeros for two edges; capturing earlier would latch them
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      strap_age <= '0;
    end else if (clk_en) begin
      strap_age <= {strap_age[0], 1'b1};
    end
  end

  // straps are caught once, after reset release, once synchronised
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      strap_seen <= 1'b0;
      straps     <= '0;
    end else if (clk_en && strap_age[1] && !strap_seen) begin
      strap_seen                <= 1'b1;
      straps.active_low_enable  <= ~strap_sync[2];
      straps.individual_power   <= ~strap_sync[1];
      straps.full_power_mgmt    <= ~strap_sync[0];
    end
  end

  assign grouped_on = |port_power_req;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reserved_bit        <= 1'b0;
      target_if_reset     <= 1'b0;
      upstream_connect_en <= 1'b0;
      full_power_mgmt_en  <= 1'b0;
      power_switch_en     <= '0;
    end else if (clk_en) begin
      reserved_bit        <= reserved_config_bit;
      target_if_reset     <= target_interface_reset;
      upstream_connect_en <= strap_seen && !configuration_in_progress;
      full_power_mgmt_en  <= strap_seen && straps.full_power_mgmt;
      for (int i = 0; i < NUM_PORTS; i++) begin
        power_switch_en[i] <= (straps.individual_power ? port_power_req[i] : grouped_on)
                              ^ straps.active_low_enable;
      end
    end
  end

  // assertions other than read_upper_a look at enabled cycles only: a frozen cycle changes no state
  conn_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && configuration_in_progress |=> !upstream_connect_en)
    else $error("upstream connected during configuration");

  conn_open_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && strap_seen && !configuration_in_progress |=> upstream_connect_en)
    else $error("upstream held off without configuration");

  flag_w1c_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && wr_stat && host_req.wdata[HCSR_BIT_CFG_ACT] && !enter_cfg |=> !configuration_in_progress)
    else $error("flag not cleared by write one");

  flag_w0keep_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && configuration_in_progress && !leave_eeprom && !rst_done &&
    !(wr_stat && host_req.wdata[HCSR_BIT_CFG_ACT]) |=> configuration_in_progress)
    else $error("flag lost without cause");

  flag_set_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && enter_cfg |=> configuration_in_progress)
    else $error("flag not set on config entry");

  eeprom_exit_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && leave_eeprom && !enter_cfg |=> !configuration_in_progress)
    else $error("flag not cleared on eeprom exit");

  // the repeat count matches the interface reset length of four enabled cycles
  rst_selfclr_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(target_interface_reset) ##0 clk_en [*4] |=> !target_interface_reset)
    else $error("interface reset did not self clear");

  rst_w0_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && !target_interface_reset &&
    !(wr_stat && host_req.wdata[HCSR_BIT_IF_RST]) |=> !target_interface_reset)
    else $error("interface reset set without write one");

  rst_reload_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && rst_done |=> !target_interface_reset && reserved_config_bit == HCSR_RESET_VAL[HCSR_BIT_RSVD0])
    else $error("registers not reloaded by interface reset");

  eeprom_norst_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && !target_interface_reset && config_mode != HCSR_MODE_SMBUS |=> !target_interface_reset)
    else $error("interface reset set outside smbus mode");

  read_upper_a: assert property (@(posedge core_clk) disable iff (reset)
    host_rvalid |-> host_rdata[7:2] == 6'h0_0)
    else $error("reserved bits read nonzero");

  reserved_config_bit_read_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && host_req.rd && host_req.addr == HCSR_OFS_RESERVED_CONFIG_BIT_CFG |=> host_rdata[7:1] == 7'h00)
    else $error("reserved register upper bits read nonzero");

  rd_answer_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && host_req.rd |=> host_rvalid)
    else $error("read not answered");

  rvalid_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && !host_req.rd |=> !host_rvalid)
    else $error("read valid without a read");

  host_wr_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && wr_reserved_config_bit && !rst_done && !eeprom_load_valid |=>
    reserved_config_bit == $past(host_req.wdata[HCSR_BIT_RSVD0]))
    else $error("host write to reserved bit lost");

  eeprom_load_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && config_mode == HCSR_MODE_EEPROM && eeprom_load_valid && !rst_done |=>
    reserved_config_bit == $past(eeprom_reserved_config_bit_bit))
    else $error("eeprom data not loaded into reserved bit");

  reserved_config_bit_keep_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && !wr_reserved_config_bit && !rst_done && !(config_mode == HCSR_MODE_EEPROM && eeprom_load_valid) |=>
    $stable(reserved_config_bit))
    else $error("reserved bit changed without cause");

  strap_keep_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && strap_seen |=> $stable(straps))
    else $error("strap options changed after capture");

  pwr_indiv_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && strap_seen && !strap_sync[1] |=>
    power_switch_en == ($past(port_power_req) ^ {NUM_PORTS{!strap_sync[2]}}))
    else $error("individual power enables wrong");

  pwr_group_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && strap_seen && strap_sync[1] |=>
    power_switch_en == {NUM_PORTS{($past(port_power_req) != '0) ^ !strap_sync[2]}})
    else $error("grouped power enables wrong");

  fpm_en_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && strap_seen |=> full_power_mgmt_en == !strap_sync[0])
    else $error("full power management enable wrong");
endmodule : hcsr_regs
`default_nettype wire

// ===== hcsr_pkg.sv
// package: register map, field positions and shared types for the hub config/status bank
`default_nettype none
package hcsr_pkg;
  localparam logic [7:0] HCSR_OFS_RESERVED_CONFIG_BIT_CFG   = 8'h00_F2;
  localparam logic [7:0] HCSR_OFS_STATUS_CMD = 8'h00_F8;
  localparam int         HCSR_BIT_RSVD0      = 0;
  localparam int         HCSR_BIT_CFG_ACT    = 0;
  localparam int         HCSR_BIT_IF_RST     = 1;
  localparam logic [7:0] HCSR_RESET_VAL      = 8'h00_00;
  localparam logic [7:0] HCSR_ZERO_BYTE      = 8'h00_00;
  // clocks that the target interface reset takes to complete
  localparam int         HCSR_IF_RST_CYCLES  = 4;
  localparam int         HCSR_CNT_W          = 3;

  typedef enum logic [1:0] {
    HCSR_MODE_PINS,
    HCSR_MODE_EEPROM,
    HCSR_MODE_SMBUS
  } hcsr_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hcsr_req_s;

  typedef struct packed {
    logic active_low_enable;
    logic individual_power;
    logic full_power_mgmt;
  } hcsr_straps_s;
endpackage : hcsr_pkg
`default_nettype wire

// ===== hcsr_sync.sv
// two-flop synchroniser for asynchronous pin levels
`default_nettype none
module hcsr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : hcsr_sync
`default_nettype wire

// ===== hcsr_cfg_partner.sv
// configuration partner: eeprom loader and smbus mode selector facing the register bank
`default_nettype none
module hcsr_cfg_partner #(
  parameter int LOAD_DLY = 8
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset,
  // commands from the bench
  input  wire logic            eeprom_start,
  input  wire logic            smbus_sel,
  input  wire logic            stored_bit,
  // towards the bank
  output hcsr_pkg::hcsr_mode_e config_mode,
  output logic                 load_valid,
  output logic                 load_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  import hcsr_pkg::*;
  int cnt;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt         <= 0;
      config_mode <= HCSR_MODE_PINS;
      load_valid  <= 1'b0;
      load_bit    <= 1'b0;
    end else begin
      load_valid <= 1'b0;
      // data line toggles outside the load so a stale value cannot pass for data
      load_bit   <= ~load_bit;
      if (eeprom_start && cnt == 0) begin
        cnt         <= 1;
        config_mode <= HCSR_MODE_EEPROM;
      end else if (cnt != 0) begin
        cnt <= (cnt == 2 * LOAD_DLY) ? 0 : cnt + 1;
        if (cnt == LOAD_DLY) begin
          load_valid <= 1'b1;
          load_bit   <= stored_bit;
        end
        if (cnt == 2 * LOAD_DLY) config_mode <= HCSR_MODE_PINS;
      end else begin
        config_mode <= smbus_sel ? HCSR_MODE_SMBUS : HCSR_MODE_PINS;
      end
    end
  end
endmodule : hcsr_cfg_partner
`default_nettype wire

// ===== hcsr_regs_tb.sv
// self-checking bench for the hub config/status register bank
`default_nettype none
module hcsr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import hcsr_pkg::*;
  logic       core_clk, reset, clk_en, load_valid, load_bit, host_rvalid;
  logic       eeprom_start, smbus_sel, stored_bit, reserved_bit, upstream_connect_en;
  logic       target_if_reset, full_power_mgmt_en;
  logic [2:0] straps;
  logic [3:0] port_power_req, power_switch_en;
  logic [7:0] host_rdata, d;
  hcsr_mode_e config_mode;
  hcsr_req_s  host_req;
  int         n_errors, n_tests, seed, cycles;

  hcsr_cfg_partner hcsr_cfg_partner_i (.core_clk(core_clk), .reset(reset), .eeprom_start(eeprom_start),
    .smbus_sel(smbus_sel), .stored_bit(stored_bit), .config_mode(config_mode), .load_valid(load_valid),
    .load_bit(load_bit));
  hcsr_regs #(.NUM_PORTS(4)) hcsr_regs_i (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .config_mode(config_mode), .eeprom_load_valid(load_valid), .eeprom_reserved_config_bit_bit(load_bit),
    .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .high_speed_suspend_strap(straps[2]), .grouped_power_strap(straps[1]),
    .full_power_management_strap(straps[0]), .port_power_req(port_power_req), .reserved_bit(reserved_bit),
    .upstream_connect_en(upstream_connect_en), .target_if_reset(target_if_reset),
    .power_switch_en(power_switch_en), .full_power_mgmt_en(full_power_mgmt_en));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // a missing valid strobe turns the data unknown so it cannot match
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk) host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00_00};
    @(posedge core_clk) host_req <= '0;
    #1 v = host_rvalid ? host_rdata : 8'hxx;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk) host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk) host_req <= '0;
  endtask : wr

  function automatic logic [3:0] exp_pwr(input logic [3:0] r);
    logic [3:0] e;
    e = straps[1] ? {4{|r}} : r;
    return straps[2] ? e : ~e;
  endfunction : exp_pwr

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    seed = 32'h2899_374a;
    {reset, clk_en, eeprom_start, smbus_sel, stored_bit} = 5'b11000;
    host_req = '0;
    port_power_req = 4'h0;
    straps = 3'b000;
    // four strap combinations, each strap both low and high, each under a fresh reset
    for (int k = 0; k < 4; k++) begin
      reset  <= 1'b1;
      straps <= 3'(k * 5);
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      repeat (5) @(posedge core_clk);
      rd(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, d); check(d, HCSR_RESET_VAL);
      rd(HCSR_OFS_STATUS_CMD, d); check(d, HCSR_RESET_VAL);
      rd(8'h00_F5, d); check(d, HCSR_ZERO_BYTE);
      check(8'(full_power_mgmt_en), 8'(!straps[0]));
      check(8'(upstream_connect_en), 8'h00_01);
      repeat (8) begin
        @(posedge core_clk) port_power_req <= 4'($random(seed));
        repeat (2) @(posedge core_clk);
        #1 check(8'(power_switch_en), 8'(exp_pwr(port_power_req)));
      end
    end
    stored_bit   <= 1'b1;
    eeprom_start <= 1'b1;
    @(posedge core_clk) eeprom_start <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check(8'(upstream_connect_en), 8'h00_00);
    rd(HCSR_OFS_STATUS_CMD, d); check(d, 8'h00_01);
    wr(HCSR_OFS_STATUS_CMD, 8'h00_02);
    @(posedge core_clk);
    #1 check(8'(target_if_reset), 8'h00_00);
    while (config_mode != HCSR_MODE_PINS) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    rd(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, d); check(d, 8'h00_01);
    rd(HCSR_OFS_STATUS_CMD, d); check(d, 8'h00_00);
    wr(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, 8'h00_00);
    rd(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, d); check(d, 8'h00_01);
    smbus_sel <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, 8'($random(seed)) & 8'h00_FE);
    rd(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, d); check(d, 8'h00_00);
    wr(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, 8'h00_FF);
    rd(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, d); check(d, 8'h00_01);
    // a write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, 8'h00_00);
    clk_en <= 1'b1;
    rd(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, d); check(d, 8'h00_01);
    wr(HCSR_OFS_STATUS_CMD, 8'h00_FC);
    rd(HCSR_OFS_STATUS_CMD, d); check(d, 8'h00_01);
    check(8'(upstream_connect_en), 8'h00_00);
    wr(HCSR_OFS_STATUS_CMD, 8'h00_01);
    rd(HCSR_OFS_STATUS_CMD, d); check(d, 8'h00_00);
    check(8'(upstream_connect_en), 8'h00_01);
    wr(HCSR_OFS_STATUS_CMD, 8'h00_02);
    @(posedge core_clk);
    #1 check(8'(target_if_reset), 8'h00_01);
    repeat (HCSR_IF_RST_CYCLES - 1) @(posedge core_clk);
    #1 check(8'(target_if_reset), 8'h00_01);
    @(posedge core_clk);
    #1 check(8'(target_if_reset), 8'h00_00);
    check(8'(reserved_bit), 8'h00_00);
    rd(HCSR_OFS_RESERVED_CONFIG_BIT_CFG, d); check(d, HCSR_RESET_VAL);
    results();
  end
endmodule : hcsr_regs_tb
`default_nettype wire
